// [src/flash_selfprog_signature_boot.sv]
// Self-programming controller: signature read, write timing, boot decode
`timescale 1ns/1ps
module flash_selfprog_signature_boot
  import selfprog_pkg::*;
(
  input wire logic clk_sys_in, // 125 MHz system clock
  input wire logic resetn_in, // Asynchronous reset, active low
  input wire logic por_n_in, // Power-on reset, clears the write timer and time base, active low
  input wire logic ctrl_wr_in, // Control register write strobe
  input wire logic signature_read_select_in, // Signature read bit written
  input wire logic store_program_enable_in, // Store enable bit written
  input wire logic write_op_in, // Written command is a timed flash write
  input wire logic load_in, // Program-memory load executes
  input wire logic store_in, // Store-program instruction executes
  input wire logic [selfprog_pkg::PTR_W-1:0] ptr_in, // Address pointer
  input wire logic [15:0] flash_word_in, // Flash array word at pointer
  input wire logic [1:0] boot_size_select_in, // Boot size setting
  input wire logic [7:0] sig_dev1_in, // Identification byte 1
  input wire logic [7:0] sig_dev2_in, // Identification byte 2
  input wire logic [7:0] sig_dev3_in, // Identification byte 3
  input wire logic [7:0] rc_cal_in, // Oscillator calibration byte
  input wire logic [7:0] temp_offset_cal_byte_in, // Temperature offset
  input wire logic [7:0] temp_gain_cal_byte_in, // Temperature gain
  output logic [7:0] load_data_out, // Byte returned to load destination
  output logic load_valid_out, // Load data valid pulse
  output logic signature_read_select_out, // Signature read bit readback
  output logic store_program_enable_out, // Store enable / busy bit
  output logic flash_write_start_out, // Starts a flash write pulse
  output logic flash_write_done_out, // Flash write complete pulse
  output logic [12:0] boot_start_out, // Boot reset address
  output logic [12:0] app_end_out, // Last application word
  output logic [11:0] boot_words_out // Boot section size in words
);
  import selfprog_pkg::*;

  // ==========================================
  // Reset synchroniser
  // Release is synchronised so every flop on rst_sync_ff leaves reset on the same edge
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Power-on reset synchroniser, used to keep a write alive over system reset
  logic por_meta_ff;
  logic por_sync_ff;
  always_ff @(posedge clk_sys_in or negedge por_n_in) begin
    if (!por_n_in) begin
      por_meta_ff <= 1'b0;
      por_sync_ff <= 1'b0;
    end else begin
      por_meta_ff <= 1'b1;
      por_sync_ff <= por_meta_ff;
    end
  end

  // ==========================================
  // RC oscillator time base
  // Flash timing runs from this tick, never from the instruction rate
  logic rc_tick;
  rc_tick_gen #(.DIV(RC_DIV)) u_rc_tick (
    .clk_in(clk_sys_in),
    .rst_n_in(por_sync_ff),
    .tick_out(rc_tick)
  );

  // ==========================================
  // Write timer: survives system reset, only power-on reset clears it
  // The tick count is rounded up, but the first tick can come one cycle after the start, so a write can end 4 cycles short of the minimum time
  localparam int TMR_W = 16;
  localparam logic [TMR_W-1:0] LAST_TICK_C = TMR_W'(WRITE_TICKS - 1);
  logic [TMR_W-1:0] wr_cnt_ff;
  logic [TMR_W-1:0] nxt_wr_cnt;
  logic wr_busy_ff;
  logic nxt_wr_busy;
  logic wr_done_ff;
  wire logic wr_start;
  wire logic wr_tick = wr_busy_ff && rc_tick;
  wire logic wr_at_end = (wr_cnt_ff == LAST_TICK_C);
  wire logic wr_last = wr_tick && wr_at_end;

  // A start reloads the timer, the last tick ends the write
  always_comb begin
    nxt_wr_cnt = wr_cnt_ff;
    nxt_wr_busy = wr_busy_ff;
    if (wr_start) begin
      nxt_wr_busy = 1'b1;
      nxt_wr_cnt = '0;
    end else if (wr_last) begin
      nxt_wr_busy = 1'b0;
    end else if (wr_tick) begin
      nxt_wr_cnt = wr_cnt_ff + TMR_W'(1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge por_sync_ff) begin
    if (!por_sync_ff) begin
      wr_cnt_ff <= '0;
      wr_busy_ff <= 1'b0;
    end else begin
      wr_cnt_ff <= nxt_wr_cnt;
      wr_busy_ff <= nxt_wr_busy;
    end
  end

  always_ff @(posedge clk_sys_in or negedge por_sync_ff) begin
    if (!por_sync_ff) begin
      wr_done_ff <= 1'b0;
    end else begin
      wr_done_ff <= wr_last;
    end
  end

  // ==========================================
  // Control state machine
  prog_state_t state_ff;
  prog_state_t nxt_state;
  logic [2:0] win_ff;
  logic [2:0] nxt_win;
  // Command decode of a control register write
  wire logic sig_cmd = signature_read_select_in && store_program_enable_in;
  wire logic store_cmd = store_program_enable_in && !signature_read_select_in && write_op_in;
  wire logic arm_sig = ctrl_wr_in && sig_cmd;
  wire logic arm_store = ctrl_wr_in && store_cmd;
  // Loads and stores only count while the matching bits are armed
  wire logic store_ptr_ok = !ptr_in[0];
  wire logic sig_hit = (state_ff == ST_SIG_ARMED) && load_in;
  wire logic store_hit = (state_ff == ST_STORE_ARMED) && store_in && store_ptr_ok;
  assign wr_start = store_hit && !wr_busy_ff;
  // Arming opens a window of cycles; the bits drop when it runs out
  wire logic win_last = (win_ff == 3'h1);
  wire logic [2:0] win_dec = win_ff - 3'h1;

  always_comb begin
    nxt_state = state_ff;
    nxt_win = win_ff;
    case (state_ff)
      ST_IDLE: begin
        if (arm_sig && !wr_busy_ff) begin
          nxt_state = ST_SIG_ARMED;
          nxt_win = 3'(LOAD_WINDOW);
        end else if (arm_store && !wr_busy_ff) begin
          nxt_state = ST_STORE_ARMED;
          nxt_win = 3'(STORE_WINDOW);
        end
      end
      ST_SIG_ARMED: begin
        if (sig_hit || win_last) begin
          nxt_state = ST_IDLE;
        end
        nxt_win = win_dec;
      end
      ST_STORE_ARMED: begin
        if (store_hit) begin
          nxt_state = ST_WRITE_BUSY;
        end else if (win_last) begin
          nxt_state = ST_IDLE;
        end
        nxt_win = win_dec;
      end
      ST_WRITE_BUSY: begin
        if (!wr_busy_ff) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // State register; system reset returns to idle but leaves a running write alone
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Window counter for the armed bits
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      win_ff <= 3'h0;
    end else begin
      win_ff <= nxt_win;
    end
  end

  // ==========================================
  // Signature row lookup
  wire logic hit_dev1 = (ptr_in == SIG_ADDR_DEV1);
  wire logic hit_dev2 = (ptr_in == SIG_ADDR_DEV2);
  wire logic hit_dev3 = (ptr_in == SIG_ADDR_DEV3);
  wire logic hit_rccal = (ptr_in == SIG_ADDR_RCCAL);
  wire logic hit_toff = (ptr_in == SIG_ADDR_TOFF);
  wire logic hit_tgain = (ptr_in == SIG_ADDR_TGAIN);
  // Reserved addresses return a fixed filler byte
  wire logic [7:0] sig_byte =
    hit_dev1 ? sig_dev1_in :
    hit_dev2 ? sig_dev2_in :
    hit_dev3 ? sig_dev3_in :
    hit_rccal ? rc_cal_in :
    hit_toff ? temp_offset_cal_byte_in :
    hit_tgain ? temp_gain_cal_byte_in :
    SIG_RESERVED_VAL;
  wire logic byte_hi = ptr_in[0];
  wire logic [7:0] flash_byte = byte_hi ? flash_word_in[15:8] : flash_word_in[7:0];
  wire logic [7:0] load_byte = sig_hit ? sig_byte : flash_byte;

  // ==========================================
  // Boot section decode
  wire logic size_11 = (boot_size_select_in == 2'b11);
  wire logic size_10 = (boot_size_select_in == 2'b10);
  wire logic size_01 = (boot_size_select_in == 2'b01);
  wire logic [12:0] boot_start =
    size_11 ? BOOT_START_11 :
    size_10 ? BOOT_START_10 :
    size_01 ? BOOT_START_01 :
    BOOT_START_00;
  // The section always ends at the top word, so the application ends just below
  wire logic [12:0] app_end = boot_start - 13'h1;
  wire logic [11:0] boot_words =
    size_11 ? BOOT_WORDS_11 :
    size_10 ? BOOT_WORDS_10 :
    size_01 ? BOOT_WORDS_01 :
    BOOT_WORDS_00;

  // ==========================================
  // Registered outputs
  wire logic nxt_sig_bit = (nxt_state == ST_SIG_ARMED);
  // Busy covers the start cycle and the whole write; a system reset taken during it clears the bit until the synchronised reset releases
  wire logic nxt_en_bit = (nxt_state != ST_IDLE) || wr_busy_ff || wr_start;
  wire logic [7:0] nxt_load_data = load_in ? load_byte : load_data_out;

  // Load data holds between loads
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      load_data_out <= 8'h00;
    end else begin
      load_data_out <= nxt_load_data;
    end
  end

  // Load valid pulse, one cycle after the load
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      load_valid_out <= 1'b0;
    end else begin
      load_valid_out <= load_in;
    end
  end

  // Control bit readback; the enable bit doubles as the busy flag
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      signature_read_select_out <= 1'b0;
      store_program_enable_out <= 1'b0;
    end else begin
      signature_read_select_out <= nxt_sig_bit;
      store_program_enable_out <= nxt_en_bit;
    end
  end

  // Write start and done pulses
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      flash_write_start_out <= 1'b0;
      flash_write_done_out <= 1'b0;
    end else begin
      flash_write_start_out <= wr_start;
      flash_write_done_out <= wr_done_ff;
    end
  end

  // Boot decode outputs; reset shows the largest section
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      boot_start_out <= BOOT_START_00;
      app_end_out <= BOOT_START_00 - 13'h1;
      boot_words_out <= BOOT_WORDS_00;
    end else begin
      boot_start_out <= boot_start;
      app_end_out <= app_end;
      boot_words_out <= boot_words;
    end
  end
endmodule : flash_selfprog_signature_boot

// [src/selfprog_pkg.sv]
// Constants and types shared by the self-programming controller
package selfprog_pkg;
  // ==========================================
  // Clock and timing
  localparam int CLK_MHZ = 125;
  localparam int RC_MHZ = 8;
  localparam int WRITE_MIN_US = 3700;
  localparam int WRITE_MAX_US = 4500;
  localparam int RC_DIV = CLK_MHZ / RC_MHZ;
  // Ticks of the divided time base, rounded up; a partial first tick can still end a write 4 cycles early
  localparam int WRITE_TICKS = (WRITE_MIN_US * CLK_MHZ) / RC_DIV + 1;
  localparam int LOAD_WINDOW = 3;
  localparam int STORE_WINDOW = 4;
  // ==========================================
  // Pointer and data widths
  localparam int PTR_W = 16;
  localparam int WADDR_W = 13;
  localparam int BYTE_W = 8;
  // ==========================================
  // Signature row addresses
  localparam logic [15:0] SIG_ADDR_DEV1 = 16'h0000;
  localparam logic [15:0] SIG_ADDR_RCCAL = 16'h0001;
  localparam logic [15:0] SIG_ADDR_DEV2 = 16'h0002;
  localparam logic [15:0] SIG_ADDR_DEV3 = 16'h0004;
  localparam logic [15:0] SIG_ADDR_TOFF = 16'h0005;
  localparam logic [15:0] SIG_ADDR_TGAIN = 16'h0007;
  localparam logic [7:0] SIG_RESERVED_VAL = 8'hFF;
  // ==========================================
  // Boot section decode
  localparam logic [12:0] BOOT_START_11 = 13'h1F00;
  localparam logic [12:0] BOOT_START_10 = 13'h1E00;
  localparam logic [12:0] BOOT_START_01 = 13'h1C00;
  localparam logic [12:0] BOOT_START_00 = 13'h1800;
  localparam logic [12:0] BOOT_END = 13'h1FFF;
  localparam logic [11:0] BOOT_WORDS_11 = 12'h100;
  localparam logic [11:0] BOOT_WORDS_10 = 12'h200;
  localparam logic [11:0] BOOT_WORDS_01 = 12'h400;
  localparam logic [11:0] BOOT_WORDS_00 = 12'h800;
  // ==========================================
  // Controller states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SIG_ARMED,
    ST_STORE_ARMED,
    ST_WRITE_BUSY
  } prog_state_t;
endpackage : selfprog_pkg

// [src/rc_tick_gen.sv]
// Divider producing the internal RC-oscillator time base tick
`timescale 1ns/1ps
module rc_tick_gen #(
  parameter int DIV = 16
) (
  input wire logic clk_in, // System clock
  input wire logic rst_n_in, // Synchronised reset, active low
  output logic tick_out // One-cycle tick per oscillator period
);
  logic [7:0] cnt_ff;
  wire logic wrap = (cnt_ff == 8'(DIV - 1));
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff <= 8'h00;
      tick_out <= 1'b0;
    end else begin
      cnt_ff <= wrap ? 8'h00 : cnt_ff + 8'h01;
      tick_out <= wrap;
    end
  end
endmodule : rc_tick_gen

// [dv/selfprog_assertions.sv]
// Concurrent checks on the self-programming controller ports
`timescale 1ns/1ps
module selfprog_assertions
  import selfprog_pkg::*;
(
  input wire logic clk_sys_in, // System clock
  input wire logic resetn_in, // Reset, active low
  input wire logic por_n_in, // Power-on reset, active low
  input wire logic load_in, // Load strobe
  input wire logic [selfprog_pkg::PTR_W-1:0] ptr_in, // Pointer
  input wire logic [15:0] flash_word_in, // Flash word
  input wire logic [7:0] sig_dev1_in, // Identification byte 1
  input wire logic [7:0] load_data_out, // Load data
  input wire logic load_valid_out, // Load valid
  input wire logic signature_read_select_out, // Signature bit
  input wire logic store_program_enable_out, // Enable / busy bit
  input wire logic flash_write_start_out, // Write start pulse
  input wire logic flash_write_done_out, // Write done pulse
  input wire logic [12:0] boot_start_out, // Boot reset address
  input wire logic [12:0] app_end_out, // Last application word
  input wire logic [11:0] boot_words_out // Boot size
);
  import selfprog_pkg::*;
  // ==========================================
  // Write duration counter, survives system reset
  logic [19:0] wr_cnt_ff;
  always_ff @(posedge clk_sys_in or negedge por_n_in) begin
    if (!por_n_in) wr_cnt_ff <= 20'h0;
    else if (flash_write_start_out) wr_cnt_ff <= 20'h1;
    else if (wr_cnt_ff != 20'h0 && wr_cnt_ff != 20'hFFFFF) wr_cnt_ff <= wr_cnt_ff + 20'h1;
  end
  // ==========================================
  // Properties
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  property p_load_valid; load_in |=> load_valid_out; endproperty
  a_load_valid: assert property (p_load_valid) else $error("load not answered");
  property p_sig_timeout;
    $rose(signature_read_select_out) ##0 (!load_in)[*3] |=> !signature_read_select_out;
  endproperty
  a_sig_timeout: assert property (p_sig_timeout) else $error("sig bit kept");
  property p_sig_done;
    load_in && signature_read_select_out |=> !signature_read_select_out && !store_program_enable_out;
  endproperty
  a_sig_done: assert property (p_sig_done) else $error("bits not cleared");
  property p_sig_dev1;
    load_in && signature_read_select_out && ptr_in == SIG_ADDR_DEV1
      |=> load_data_out == $past(sig_dev1_in);
  endproperty
  a_sig_dev1: assert property (p_sig_dev1) else $error("bad id byte");
  property p_plain_read;
    load_in && !signature_read_select_out && !store_program_enable_out |=> load_data_out ==
      ($past(ptr_in[0]) ? $past(flash_word_in[15:8]) : $past(flash_word_in[7:0]));
  endproperty
  a_plain_read: assert property (p_plain_read) else $error("bad flash byte");
  property p_boot_sum; ({1'b0, boot_start_out} + {2'b00, boot_words_out}) == 14'h2000; endproperty
  a_boot_sum: assert property (p_boot_sum) else $error("boot end wrong");
  property p_app_end; app_end_out == boot_start_out - 13'h1; endproperty
  a_app_end: assert property (p_app_end) else $error("app end wrong");
  property p_busy_hold; $rose(flash_write_start_out) |-> store_program_enable_out[*8]; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped");
  property p_min_time; flash_write_done_out |-> wr_cnt_ff >= 20'd462500; endproperty
  a_min_time: assert property (p_min_time) else $error("write too short");
  c_sig: cover property (load_in && signature_read_select_out);
  c_write: cover property (flash_write_start_out);
  c_high: cover property (load_in && !signature_read_select_out && ptr_in[0]);
endmodule : selfprog_assertions
bind flash_selfprog_signature_boot selfprog_assertions i_selfprog_assertions (.clk_sys_in,
  .resetn_in, .por_n_in, .load_in, .ptr_in, .flash_word_in, .sig_dev1_in, .load_data_out,
  .load_valid_out, .signature_read_select_out, .store_program_enable_out,
  .flash_write_start_out, .flash_write_done_out, .boot_start_out, .app_end_out, .boot_words_out);

// [dv/cpu_model.sv]
// CPU core model issuing control writes, loads and stores
`timescale 1ns/1ps
module cpu_model (
  input wire logic clk_in, // System clock
  input wire logic busy_in, // Enable bit readback
  output logic ctrl_wr_out, // Control write strobe
  output logic sig_out, // Signature bit
  output logic en_out, // Enable bit
  output logic wop_out, // Timed write command
  output logic load_out, // Load strobe
  output logic store_out, // Store strobe
  output logic [15:0] ptr_out // Pointer
);
  initial begin
    {ctrl_wr_out, sig_out, en_out, wop_out, load_out, store_out} = 6'h00;
    ptr_out = 16'h0000;
  end
  // All tasks start just after a falling edge
  task automatic ctrl(input logic s, input logic e, input logic w);
    int n;
    for (n = 0; n < 8 && busy_in !== 1'b0; n++) @(negedge clk_in);
    {ctrl_wr_out, sig_out, en_out, wop_out} = {1'b1, s, e, w};
    @(negedge clk_in);
    {ctrl_wr_out, sig_out, en_out, wop_out} = {1'b0, ~s, ~e, ~w};
  endtask : ctrl
  task automatic ld(input logic [15:0] p);
    {load_out, ptr_out} = {1'b1, p};
    @(negedge clk_in);
    {load_out, ptr_out} = {1'b0, ~p};
  endtask : ld
  task automatic st(input logic [15:0] p);
    {store_out, ptr_out} = {1'b1, p};
    @(negedge clk_in);
    {store_out, ptr_out} = {1'b0, ~p};
  endtask : st
endmodule : cpu_model

// [dv/testbench.sv]
// Self-checking bench for the self-programming controller
`timescale 1ns/1ps
module testbench;
  import selfprog_pkg::*;
  logic clk_sys_in = 1'b0, resetn_in = 1'b0, por_n_in = 1'b0;
  logic ctrl_wr_in, signature_read_select_in, store_program_enable_in, write_op_in;
  logic load_in, store_in, load_valid_out, signature_read_select_out, store_program_enable_out;
  logic flash_write_start_out, flash_write_done_out;
  logic [15:0] ptr_in, flash_word_in = 16'h0000, w;
  logic [1:0] boot_size_select_in = 2'b00;
  logic [7:0] sig_dev1_in, sig_dev2_in, sig_dev3_in, rc_cal_in, d, load_data_out;
  logic [7:0] temp_offset_cal_byte_in, temp_gain_cal_byte_in, sb [6];
  logic [15:0] sa [6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0005, 16'h0007};
  logic [12:0] boot_start_out, app_end_out;
  logic [11:0] boot_words_out;
  int miscompares = 0, cmp_count = 0, seed = 32'h5ee6, starts = 0, dones = 0, i;
  always #4 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    if (flash_write_start_out === 1'b1) starts++;
    if (flash_write_done_out === 1'b1) dones++;
  end
  initial begin
    {sig_dev1_in, sig_dev2_in, sig_dev3_in} = $random(seed);
    {rc_cal_in, temp_offset_cal_byte_in, temp_gain_cal_byte_in} = $random(seed);
  end
  cpu_model i_cpu_model (.clk_in(clk_sys_in), .busy_in(store_program_enable_out),
    .ctrl_wr_out(ctrl_wr_in), .sig_out(signature_read_select_in), .en_out(store_program_enable_in),
    .wop_out(write_op_in), .load_out(load_in), .store_out(store_in), .ptr_out(ptr_in));
  flash_selfprog_signature_boot i_flash_selfprog_signature_boot (.clk_sys_in, .resetn_in,
    .por_n_in, .ctrl_wr_in, .signature_read_select_in, .store_program_enable_in, .write_op_in,
    .load_in, .store_in, .ptr_in, .flash_word_in, .boot_size_select_in, .sig_dev1_in,
    .sig_dev2_in, .sig_dev3_in, .rc_cal_in, .temp_offset_cal_byte_in, .temp_gain_cal_byte_in,
    .load_data_out, .load_valid_out, .signature_read_select_out, .store_program_enable_out,
    .flash_write_start_out, .flash_write_done_out, .boot_start_out, .app_end_out,
    .boot_words_out);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] exp_byte(input logic [15:0] word, input logic hi);
    return hi ? word[15:8] : word[7:0];
  endfunction : exp_byte
  task automatic results;
    $display("compares=%0d miscompares=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  task automatic get_load(input logic [15:0] p, output logic [7:0] q);
    int n;
    i_cpu_model.ld(p);
    for (n = 0; n < 3 && load_valid_out !== 1'b1; n++) @(negedge clk_sys_in);
    if (n == 3) begin
      miscompares++;
      results();
    end
    q = load_data_out;
  endtask : get_load
  initial begin
    repeat (6) @(negedge clk_sys_in);
    sb = '{sig_dev1_in, rc_cal_in, sig_dev2_in, sig_dev3_in, temp_offset_cal_byte_in,
      temp_gain_cal_byte_in};
    {resetn_in, por_n_in} = 2'b11;
    repeat (3) @(negedge clk_sys_in);
    for (i = 0; i < 4; i++) begin
      boot_size_select_in = i[1:0];
      repeat (3) @(negedge clk_sys_in);
      w = 16'h0100 << (3 - i);
      check(16'(boot_words_out), w);
      check(16'(boot_start_out), 16'h2000 - w);
      check(16'(app_end_out), 16'h1FFF - w);
    end
    for (i = 0; i < 8; i++) begin
      flash_word_in = $random(seed);
      w = $random(seed);
      get_load(w, d);
      check(16'(d), 16'(exp_byte(flash_word_in, w[0])));
    end
    for (i = 0; i < 6; i++) begin
      i_cpu_model.ctrl(1'b1, 1'b1, 1'b0);
      repeat ({$random(seed)} % 3) @(negedge clk_sys_in);
      get_load(sa[i], d);
      check(16'(d), 16'(sb[i]));
      @(negedge clk_sys_in);
      check(16'({signature_read_select_out, store_program_enable_out}), 16'h0);
    end
    i_cpu_model.ctrl(1'b1, 1'b1, 1'b0);
    @(negedge clk_sys_in);
    check(16'(signature_read_select_out), 16'h1);
    repeat (4) @(negedge clk_sys_in);
    check(16'({signature_read_select_out, store_program_enable_out}), 16'h0);
    flash_word_in = 16'hA55A;
    get_load(16'h0001, d);
    check(16'(d), 16'h00A5);
    i_cpu_model.ctrl(1'b0, 1'b1, 1'b1);
    i_cpu_model.st(16'h0041);
    repeat (6) @(negedge clk_sys_in);
    check(16'({store_program_enable_out, starts != 0}), 16'h0);
    i_cpu_model.ctrl(1'b0, 1'b1, 1'b1);
    i_cpu_model.st(16'h0040);
    repeat (2000) @(negedge clk_sys_in);
    check(16'({store_program_enable_out, starts == 1, dones != 0}), 16'h6);
    resetn_in = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    resetn_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    check(16'(store_program_enable_out), 16'h1);
    results();
  end
endmodule : testbench
